/* uarv_defines.svh */
// register map, field positions and reset values of the receive port
`ifndef UARV_DEFINES_SVH
`define UARV_DEFINES_SVH

// byte addresses on the register bus
`define UARV_A_CTRL   12'h000
`define UARV_A_ADDR   12'h004
`define UARV_A_MASK   12'h008
`define UARV_A_DIV    12'h00c
`define UARV_A_STS    12'h010
`define UARV_A_DATA   12'h014

// control register fields
`define UARV_C_AM     2:0
`define UARV_C_PAR    4:3
`define UARV_C_STOP2  5
`define UARV_C_VOTE   6
`define UARV_C_OS16   7
`define UARV_C_HDX    8
`define UARV_C_EN     9

// address station fields
`define UARV_D_ADDR1  7:0
`define UARV_D_ADDR2  15:8

// address modes
`define UARV_AM_NONE   3'h0
`define UARV_AM_SW_BB  3'h1
`define UARV_AM_SW_DTB 3'h2
`define UARV_AM_HW_BB  3'h3
`define UARV_AM_HW_DTB 3'h4

// parity types
`define UARV_PAR_NONE 2'h0
`define UARV_PAR_EVEN 2'h1
`define UARV_PAR_ODD  2'h2
`define UARV_PAR_MS   2'h3

// status bit positions
`define UARV_S_MARK   0
`define UARV_S_BRK    1
`define UARV_S_PERR   2
`define UARV_S_FRM    3
`define UARV_S_OVR    4
`define UARV_S_QUE    5
`define UARV_S_HIT    6
`define UARV_STICKY   7'h5f

// reset values
`define UARV_CTRL_RST 10'h000
`define UARV_ADDR_RST 16'h0000
`define UARV_MASK_RST 7'h00
`define UARV_DIV_RST  16'h0000

// oversampling geometry: half bit and last phase, 8x and 16x
`define UARV_HALF8    4'h4
`define UARV_HALF16   4'h8
`define UARV_LAST8    4'h7
`define UARV_LAST16   4'hf
`define UARV_LAST_BIT 3'h7

`endif

/* uarv_pkg.sv */
// shared types of the receive port
package uarv_pkg;

  typedef enum logic [2:0] {
    UARV_IDLE,
    UARV_CHECK_START,
    UARV_COLLECT_BITS_STATE,
    UARV_PARITY,
    UARV_STOP1,
    UARV_STOP2
  } uarv_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } uarv_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uarv_apb_rsp_t;

endpackage

/* uarv_rx.sv */
// receive side of an asynchronous serial port with address filtering and apb registers
//
// How it works
// - hardware byte-by-byte mode drops characters of packets not addressed to us
// - hardware detect-to-buffer mode also withholds the address byte itself
// - stop period is one or two bit times
// - with two stop bits only the first is checked for framing
// - character order: start, data, optional parity, stop bits
// - voting takes majority of three centre samples, else one centre sample
// - falling edge enters start check and loads half-bit counter, which then counts down
// - at zero three samples; two or more low enters collection, else idle
// - 8x voting counts ones on cycles 3 to 5, captured on fifth
// - 8x without voting samples fourth edge then every eighth
// - 16x voting counts ones on cycles 7 to 9, captured on ninth
// - 16x without voting samples eighth edge then every sixteenth
// - receive status register is read-only
// - interrupt is OR of status bits gated by writable mask
// - sticky bits hold until software reads the status register
// - status registered each clock; transparent bits unaffected by reads
// - sticky mark seen in parity slot, only in address modes 1 to 4
// - sticky break and parity error flags
// - sticky framing error when stop bit sampled low
// - sticky overrun when the queue cannot take a character
// - transparent bit shows the queue holds an entry
// - sticky hit when address byte equals either station; half duplex first only
// - 3-bit field selects the address mode
`include "uarv_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module uarv_rx #(
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // register bus
  input  wire uarv_pkg::uarv_apb_req_t apb_req,
  output var  uarv_pkg::uarv_apb_rsp_t apb_rsp,
  // serial line and interrupt
  input  wire logic                    rx_pin,
  output logic                         rx_irq
);
  import uarv_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    uarv_state_t            st;
    logic                   rx_s1;
    logic                   rx_s2;
    logic                   rx_prev;
    logic [15:0]            div_cnt;
    logic [3:0]             ph;
    logic [3:0]             hcnt;
    logic [1:0]             ones;
    logic [2:0]             bitn;
    logic [7:0]             shf;
    logic                   par_bit;
    logic [9:0]             ctrl;
    logic [15:0]            addr;
    logic [6:0]             mask;
    logic [15:0]            div;
    logic [6:0]             sts;
    logic                   in_pkt;
    logic [DEPTH-1:0][7:0]  mem;
    logic [AW-1:0]          wp;
    logic [AW-1:0]          rp;
    logic [CW-1:0]          cnt;
    uarv_apb_rsp_t          rsp;
    logic                   irq;
  } uarv_regs_t;

  uarv_regs_t s_r;
  uarv_regs_t s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // derived terms
  logic       rx;
  logic       os16;
  logic       vote;
  logic [3:0] half;
  logic [3:0] last_ph;
  logic       in_win;
  logic [1:0] ones_sum;
  logic       majority;
  logic       capture;
  logic       bit_val;
  logic [2:0] am;
  logic [1:0] par_type;
  logic       par_en;
  logic       acc;
  logic       done;
  logic       full;
  logic       pop;
  logic       tick;

  assign rx       = s_r.rx_s2;
  assign os16     = s_r.ctrl[`UARV_C_OS16];
  assign vote     = s_r.ctrl[`UARV_C_VOTE];
  assign half     = os16 ? `UARV_HALF16 : `UARV_HALF8;
  assign last_ph  = os16 ? `UARV_LAST16 : `UARV_LAST8;
  assign am       = s_r.ctrl[`UARV_C_AM];
  assign par_type = s_r.ctrl[`UARV_C_PAR];
  assign par_en   = (par_type != `UARV_PAR_NONE);
  assign tick     = s_r.ctrl[`UARV_C_EN] && (s_r.div_cnt == s_r.div);
  // ones counter window spans the three centre phases
  assign in_win   = (s_r.ph >= half - 4'h1) && (s_r.ph <= half + 4'h1);
  assign ones_sum = (s_r.ph == half - 4'h1) ? {1'b0, rx} : s_r.ones + {1'b0, rx};
  assign majority = (ones_sum >= 2'h2);
  assign capture  = tick && (vote ? (s_r.ph == half + 4'h1) : (s_r.ph == half));
  assign bit_val  = vote ? majority : rx;
  assign acc      = apb_req.psel && apb_req.penable;
  assign done     = acc && s_r.rsp.pready;
  assign full     = (s_r.cnt == CW'(DEPTH));
  assign pop      = done && !apb_req.pwrite && (apb_req.paddr == `UARV_A_DATA) && (s_r.cnt != '0);

  // character evaluation terms, valid while in the first stop bit
  logic       is_addr;
  logic       match;
  logic       frm_err;
  logic       brk;
  logic       par_err;
  logic       addr_on;

  assign addr_on = (am >= `UARV_AM_SW_BB) && (am <= `UARV_AM_HW_DTB);
  assign is_addr = (par_type == `UARV_PAR_MS) && s_r.par_bit;
  assign match   = (s_r.shf == s_r.addr[`UARV_D_ADDR1]) ||
                   (!s_r.ctrl[`UARV_C_HDX] && (s_r.shf == s_r.addr[`UARV_D_ADDR2]));
  assign frm_err = !bit_val;
  assign brk     = !bit_val && (s_r.shf == 8'h00) && !(par_en && s_r.par_bit);
  assign par_err = ((par_type == `UARV_PAR_EVEN) && (^{s_r.shf, s_r.par_bit})) ||
                   ((par_type == `UARV_PAR_ODD) && !(^{s_r.shf, s_r.par_bit}));

  logic [6:0] set;
  logic       push;
  logic       keep;
  logic [6:0] clr;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_nxt = s_r;
    set   = '0;
    push  = 1'b0;
    keep  = 1'b0;
    clr   = '0;
    s_nxt.rx_s1 = rx_pin;
    s_nxt.rx_s2 = s_r.rx_s1;

    // oversampling tick divider
    if (!s_r.ctrl[`UARV_C_EN] || tick)
      s_nxt.div_cnt = '0;
    else
      s_nxt.div_cnt = s_r.div_cnt + 16'h0001;

    if (tick)
    begin
      s_nxt.rx_prev = rx;
      s_nxt.ph      = (s_r.ph == last_ph) ? 4'h0 : s_r.ph + 4'h1;
      if (in_win)
        s_nxt.ones = ones_sum;
    end

    unique case (s_r.st)
      UARV_IDLE:
      begin
        if (tick && s_r.rx_prev && !rx)
        begin
          s_nxt.st   = UARV_CHECK_START;
          s_nxt.ph   = 4'h0;
          s_nxt.hcnt = half - 4'h1;
        end
      end
      UARV_CHECK_START:
      begin
        if (tick && s_r.hcnt != 4'h0)
          s_nxt.hcnt = s_r.hcnt - 4'h1;
        else if (tick && s_r.ph == half + 4'h1)
        begin
          s_nxt.bitn = 3'h0;
          s_nxt.st   = majority ? UARV_IDLE : UARV_COLLECT_BITS_STATE;
        end
      end
      UARV_COLLECT_BITS_STATE:
      begin
        if (capture)
        begin
          s_nxt.shf  = {bit_val, s_r.shf[7:1]};
          s_nxt.bitn = s_r.bitn + 3'h1;
          if (s_r.bitn == `UARV_LAST_BIT)
            s_nxt.st = par_en ? UARV_PARITY : UARV_STOP1;
        end
      end
      UARV_PARITY:
      begin
        if (capture)
        begin
          s_nxt.par_bit = bit_val;
          s_nxt.st      = UARV_STOP1;
        end
      end
      UARV_STOP1:
      begin
        if (capture)
        begin
          set[`UARV_S_FRM]  = frm_err;
          set[`UARV_S_BRK]  = brk;
          set[`UARV_S_PERR] = par_err;
          set[`UARV_S_MARK] = addr_on && is_addr;
          set[`UARV_S_HIT]  = addr_on && is_addr && match;
          keep = !brk;
          if (am == `UARV_AM_HW_BB)
          begin
            if (is_addr)
              s_nxt.in_pkt = match;
            keep = keep && (is_addr ? match : s_r.in_pkt);
          end
          else if (am == `UARV_AM_HW_DTB)
          begin
            if (is_addr)
              s_nxt.in_pkt = match;
            keep = keep && !is_addr && s_r.in_pkt;
          end
          if (keep && full)
            set[`UARV_S_OVR] = 1'b1;
          push = keep && !full;
          s_nxt.st = s_r.ctrl[`UARV_C_STOP2] ? UARV_STOP2 : UARV_IDLE;
        end
      end
      UARV_STOP2:
      begin
        // second stop bit only spaces characters; its level is not checked
        if (capture)
          s_nxt.st = UARV_IDLE;
      end
    endcase

    // receive queue
    if (push)
    begin
      s_nxt.mem[s_r.wp] = s_r.shf;
      s_nxt.wp          = s_r.wp + AW'(1);
    end
    if (pop)
      s_nxt.rp = s_r.rp + AW'(1);
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);

    // register bus: one wait cycle, data launched with pready
    s_nxt.rsp.pready  = acc && !s_r.rsp.pready;
    if (acc && !s_r.rsp.pready)
    begin
      s_nxt.rsp.pslverr = 1'b0;
      s_nxt.rsp.prdata  = '0;
      unique case (apb_req.paddr)
        `UARV_A_CTRL: s_nxt.rsp.prdata = {22'h000000, s_r.ctrl};
        `UARV_A_ADDR: s_nxt.rsp.prdata = {16'h0000, s_r.addr};
        `UARV_A_MASK: s_nxt.rsp.prdata = {25'h0000000, s_r.mask};
        `UARV_A_DIV:  s_nxt.rsp.prdata = {16'h0000, s_r.div};
        `UARV_A_STS:  s_nxt.rsp.prdata = {25'h0000000, s_r.sts};
        `UARV_A_DATA: s_nxt.rsp.prdata = {24'h000000, s_r.mem[s_r.rp]};
        default:      s_nxt.rsp.pslverr = 1'b1;
      endcase
    end
    if (done && apb_req.pwrite)
    begin
      unique case (apb_req.paddr)
        `UARV_A_CTRL: s_nxt.ctrl = apb_req.pwdata[9:0];
        `UARV_A_ADDR: s_nxt.addr = apb_req.pwdata[15:0];
        `UARV_A_MASK: s_nxt.mask = apb_req.pwdata[6:0];
        `UARV_A_DIV:  s_nxt.div  = apb_req.pwdata[15:0];
        // status and data ignore writes
        default:      s_nxt.ctrl = s_r.ctrl;
      endcase
    end

    // clear only the sticky bits that the completing read returned
    if (done && !apb_req.pwrite && apb_req.paddr == `UARV_A_STS)
      clr = s_r.rsp.prdata[6:0] & `UARV_STICKY;
    s_nxt.sts              = (s_r.sts & ~clr) | set;
    s_nxt.sts[`UARV_S_QUE] = (s_nxt.cnt != '0);
    s_nxt.irq              = |(s_nxt.sts & s_nxt.mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r         <= '0;
      s_r.rx_s1   <= 1'b1;
      s_r.rx_s2   <= 1'b1;
      s_r.rx_prev <= 1'b1;
      s_r.ctrl    <= `UARV_CTRL_RST;
      s_r.addr    <= `UARV_ADDR_RST;
      s_r.mask    <= `UARV_MASK_RST;
      s_r.div     <= `UARV_DIV_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign apb_rsp = s_r.rsp;
  assign rx_irq  = s_r.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  irq_or_mask_a: assert property (rx_irq == |(s_r.sts & s_r.mask))
    else $error("interrupt differs from masked status");

  sticky_hold_a: assert property (
    s_r.sts[`UARV_S_FRM] && !(done && !apb_req.pwrite && apb_req.paddr == `UARV_A_STS)
    |=> s_r.sts[`UARV_S_FRM])
    else $error("framing flag lost without a status read");

  queue_bit_a: assert property (s_r.sts[`UARV_S_QUE] == (s_r.cnt != '0))
    else $error("queue bit does not follow queue fill");

  frame_set_a: assert property (
    s_r.st == UARV_STOP1 && capture && !bit_val |=> s_r.sts[`UARV_S_FRM])
    else $error("low stop bit did not flag framing");

  second_stop_a: assert property (
    $rose(s_r.sts[`UARV_S_FRM]) |-> $past(s_r.st) == UARV_STOP1)
    else $error("framing flagged outside first stop bit");

  overrun_a: assert property (
    s_r.st == UARV_STOP1 && capture && keep && full |=> s_r.sts[`UARV_S_OVR] && $stable(s_r.wp))
    else $error("overrun not flagged or queue written");

  start_abort_a: assert property (
    s_r.st == UARV_CHECK_START && tick && s_r.hcnt == 4'h0 && s_r.ph == half + 4'h1 && majority
    |=> s_r.st == UARV_IDLE)
    else $error("start check accepted a high line");

  vote_point_a: assert property (
    s_r.st == UARV_COLLECT_BITS_STATE && capture && vote |-> s_r.ph == half + 4'h1)
    else $error("voted bit captured at wrong phase");

  single_point_a: assert property (
    s_r.st == UARV_COLLECT_BITS_STATE && capture && !vote |-> s_r.ph == half)
    else $error("single sample taken at wrong phase");

  withhold_addr_a: assert property (push && am == `UARV_AM_HW_DTB |-> !is_addr && s_r.in_pkt)
    else $error("address byte or foreign data queued");

  filter_bb_a: assert property (push && am == `UARV_AM_HW_BB && !is_addr |-> s_r.in_pkt)
    else $error("data of foreign packet queued");

  ro_status_a: assert property (
    done && apb_req.pwrite && apb_req.paddr == `UARV_A_STS
    |=> (s_r.sts & `UARV_STICKY) == (($past(s_r.sts) | $past(set)) & `UARV_STICKY))
    else $error("status changed by a write");

  duplex_hit_a: assert property (
    set[`UARV_S_HIT] && s_r.ctrl[`UARV_C_HDX] |-> s_r.shf == s_r.addr[`UARV_D_ADDR1])
    else $error("second station matched in half duplex");

  char_pushed_c: cover property (push);
  station_hit_c: cover property ($rose(s_r.sts[`UARV_S_HIT]));
  framing_c:     cover property ($rose(s_r.sts[`UARV_S_FRM]));
  two_stop_c:    cover property (s_r.st == UARV_STOP2 && capture);
  overrun_c:     cover property (set[`UARV_S_OVR]);

endmodule

`default_nettype wire

/* uarv_tx_model.sv */
// far-end serial transmitter that drives the receive line
`timescale 1ns/100ps
`default_nettype none

module uarv_tx_model (
  // clock
  input  wire logic pclk,
  // serial line
  output var  logic line
);
  // the model drives the line high while idle
  initial line = 1'b1;

  task automatic bit_out(input logic v, input int n);
    @(posedge pclk);
    line <= v;
    repeat (n - 1) @(posedge pclk);
  endtask

  // start, lsb-first data, optional parity, stop bits, then one idle bit
  task automatic send(input logic [7:0] d, input logic pen, input logic pb, input logic [1:0] stp,
                      input int nst, input int bt);
    int i;
    bit_out(1'b0, bt);
    for (i = 0; i < 8; i++)
      bit_out(d[i], bt);
    if (pen)
      bit_out(pb, bt);
    bit_out(stp[0], bt);
    if (nst == 2)
      bit_out(stp[1], bt);
    bit_out(1'b1, bt);
  endtask

  // short low pulse, too brief to be a start bit
  task automatic glitch(input int n);
    bit_out(1'b0, n);
    bit_out(1'b1, 1);
  endtask
endmodule

`default_nettype wire

/* uarv_rx_bench.sv */
// self-checking bench of the receive port
`include "uarv_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module uarv_rx_bench;
  import uarv_pkg::*;
  localparam logic [31:0] DIVV = 32'h1;
  logic          pclk;
  logic          presetn;
  uarv_apb_req_t req;
  uarv_apb_rsp_t rsp;
  logic          rx_line;
  logic          rx_irq;
  int            num_errors;
  int            checks_done;
  int            bt;
  logic [31:0]   rd;
  logic          err;

  uarv_rx #(.DEPTH(4)) DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
                            .rx_pin(rx_line), .rx_irq(rx_irq));
  uarv_tx_model far (.pclk(pclk), .line(rx_line));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (rsp.pready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      num_errors++;
      results();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic wait_irq();
    int n;
    for (n = 0; n < 4000; n++)
    begin
      @(posedge pclk);
      if (rx_irq === 1'b1)
        break;
    end
    if (n == 4000)
    begin
      num_errors++;
      results();
    end
  endtask

  task automatic cfg(input logic [2:0] am, input logic [1:0] par, input logic s2, input logic v,
                     input logic o16, input logic [6:0] m);
    apb(1'b1, `UARV_A_DIV, DIVV);
    apb(1'b1, `UARV_A_CTRL, {22'h0, 1'b1, 1'b0, o16, v, s2, par, am});
    apb(1'b1, `UARV_A_MASK, {25'h0, m});
    bt = (o16 ? 16 : 8) * (int'(DIVV) + 1);
  endtask

  task automatic drain();
    int n;
    for (n = 0; n < 8; n++)
    begin
      apb(1'b0, `UARV_A_STS, 32'h0);
      if (rd[5] !== 1'b1)
        break;
      apb(1'b0, `UARV_A_DATA, 32'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdm(`UARV_A_CTRL, 32'hffffffff, 32'h0);
    rdm(`UARV_A_STS, 32'hffffffff, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `UARV_A_STS, 32'hff);
    rdm(`UARV_A_STS, 32'hffffffff, 32'h0);
    apb(1'b1, `UARV_A_MASK, 32'h7f);
    rdm(`UARV_A_MASK, 32'hffffffff, 32'h7f);
    $display("regs done");
  endtask

  task automatic t_rates();
    int i;
    logic [7:0] d;
    for (i = 0; i < 4; i++)
    begin
      d = 8'ha6 ^ 8'(i);
      cfg(3'h0, 2'h0, 1'b0, i[0], i[1], 7'h20);
      far.send(d, 1'b0, 1'b0, 2'h3, 1, bt);
      wait_irq();
      rdm(`UARV_A_STS, 32'hffffffff, 32'h20);
      rdm(`UARV_A_STS, 32'hffffffff, 32'h20);
      rdm(`UARV_A_DATA, 32'hff, {24'h0, d});
      rdm(`UARV_A_STS, 32'hffffffff, 32'h0);
    end
    $display("rates done");
  endtask

  task automatic t_errs();
    int p;
    logic pb;
    cfg(3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 7'h08);
    far.send(8'h3c, 1'b0, 1'b0, 2'h2, 1, bt);
    wait_irq();
    apb(1'b1, `UARV_A_STS, 32'h0);
    rdm(`UARV_A_STS, 32'h0f, 32'h08);
    rdm(`UARV_A_STS, 32'h0f, 32'h00);
    repeat (2) @(posedge pclk);
    chk({31'h0, rx_irq}, 32'h0);
    drain();
    apb(1'b1, `UARV_A_MASK, 32'h02);
    far.send(8'h00, 1'b0, 1'b0, 2'h2, 1, bt);
    wait_irq();
    rdm(`UARV_A_STS, 32'h2f, 32'h0a);
    drain();
    for (p = 1; p < 3; p++)
    begin
      pb = (^8'h07) ^ (p == 2);
      cfg(3'h0, 2'(p), 1'b0, 1'b0, 1'b0, 7'h20);
      far.send(8'h07, 1'b1, pb, 2'h3, 1, bt);
      wait_irq();
      rdm(`UARV_A_STS, 32'h7f, 32'h20);
      rdm(`UARV_A_DATA, 32'hff, 32'h07);
      apb(1'b1, `UARV_A_MASK, 32'h04);
      far.send(8'h07, 1'b1, ~pb, 2'h3, 1, bt);
      wait_irq();
      rdm(`UARV_A_STS, 32'h04, 32'h04);
      drain();
    end
    $display("errors done");
  endtask

  task automatic t_stop();
    cfg(3'h0, 2'h0, 1'b1, 1'b0, 1'b0, 7'h20);
    far.send(8'hc3, 1'b0, 1'b0, 2'h1, 2, bt);
    wait_irq();
    rdm(`UARV_A_STS, 32'h7f, 32'h20);
    rdm(`UARV_A_DATA, 32'hff, 32'hc3);
    far.glitch(bt / 4);
    repeat (bt * 2) @(posedge pclk);
    rdm(`UARV_A_STS, 32'h7f, 32'h0);
    cfg(3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 7'h00);
    for (int k = 0; k < 5; k++)
      far.send(8'h10 + 8'(k), 1'b0, 1'b0, 2'h3, 1, bt);
    repeat (8) @(posedge pclk);
    rdm(`UARV_A_STS, 32'h7f, 32'h30);
    for (int k = 0; k < 4; k++)
      rdm(`UARV_A_DATA, 32'hff, 32'h10 + 32'(k));
    $display("stop and overrun done");
  endtask

  task automatic t_addr();
    int m;
    int k;
    int n;
    logic [7:0] d;
    logic       mk;
    logic       open;
    logic [7:0] q[4];
    for (m = 0; m < 5; m++)
    begin
      cfg(3'(m), 2'h3, 1'b0, 1'b1, 1'b0, 7'h00);
      apb(1'b1, `UARV_A_ADDR, 32'h5231);
      n = 0;
      open = 1'b0;
      for (k = 0; k < 4; k++)
      begin
        mk = (k % 2 == 0);
        d = mk ? ((k == 0) ? 8'h22 : (m[0] ? 8'h31 : 8'h52)) : 8'h40 + 8'(k);
        if (mk)
          open = (d == 8'h31 || d == 8'h52);
        far.send(d, 1'b1, mk, 2'h3, 1, bt);
        repeat (8) @(posedge pclk);
        if (m < 3 || (open && !(mk && m == 4)))
        begin
          q[n] = d;
          n++;
        end
      end
      chk({31'h0, rx_irq}, 32'h0);
      rdm(`UARV_A_STS, 32'h61, (m == 0) ? 32'h20 : 32'h61);
      for (k = 0; k < n; k++)
        rdm(`UARV_A_DATA, 32'hff, {24'h0, q[k]});
      rdm(`UARV_A_STS, 32'h20, 32'h0);
    end
    // half duplex: only the first station may raise the hit flag
    apb(1'b1, `UARV_A_CTRL, {22'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h3, 3'h1});
    far.send(8'h52, 1'b1, 1'b1, 2'h3, 1, bt);
    rdm(`UARV_A_STS, 32'h61, 32'h21);
    far.send(8'h31, 1'b1, 1'b1, 2'h3, 1, bt);
    rdm(`UARV_A_STS, 32'h61, 32'h61);
    drain();
    $display("address done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    req = '0;
    num_errors = 0;
    checks_done = 0;
    bt = 16;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rates();
    t_errs();
    t_stop();
    t_addr();
    results();
  end
endmodule

`default_nettype wire
